// ===== pkg/gcr_map.vh
// register offsets, field positions and reset values of the global configuration bank
`ifndef GCR_MAP_VH
`define GCR_MAP_VH

`define GCR_OFS_RANGE_STATUS   8'h10
`define GCR_OFS_PLL_PREDIV     8'h11
`define GCR_OFS_PLL_LOOP       8'h12
`define GCR_OFS_CONV_CLK       8'h13
`define GCR_OFS_SYS_CLK        8'h14
`define GCR_OFS_SER_CTRL       8'h15
`define GCR_OFS_BUS_MON        8'h16
`define GCR_OFS_EE_ST_LO       8'h17
`define GCR_OFS_EE_ST_HI       8'h18
`define GCR_OFS_CHIP_ST_LO     8'h19
`define GCR_OFS_CHIP_ST_HI     8'h1a
`define GCR_OFS_END_LO         8'h1b
`define GCR_OFS_END_HI         8'h1c

// pre-divider register
`define GCR_PREDIV_M_MSB       5
`define GCR_PREDIV_RANGE_BIT   6
`define GCR_RST_PREDIV         8'h41
// loop divider register
`define GCR_RST_LOOP           8'h0a
// converter clock register
`define GCR_CONV_INV_BIT       2
`define GCR_RST_CONV_CLK       8'h00
// system clock register
`define GCR_SYS_RATE_MSB       2
`define GCR_SYS_EE_EN_BIT      4
`define GCR_SYS_RATE_MAX       3'h6
`define GCR_RST_SYS_CLK        8'h10
// serial interface control register
`define GCR_SER_RAM_RUN_BIT    0
`define GCR_SER_SINGLE_BIT     1
`define GCR_SER_PARITY_BIT     2
`define GCR_SER_AUTOINC_BIT    3
`define GCR_SER_FAST_LSB       4
`define GCR_RST_SER_CTRL       8'h00
// bus monitor register
`define GCR_MON_EN_BIT         0
`define GCR_MON_SEL_BIT        1
`define GCR_RST_BUS_MON        8'h00
// register write masks, address register reset value
`define GCR_MASK_EE_HI         8'h0f
`define GCR_MASK_CHIP_HI       8'h3f
`define GCR_MASK_PREDIV        8'h7f
`define GCR_MASK_LOOP          8'h3f
`define GCR_MASK_CONV_CLK      8'h07
`define GCR_MASK_SYS_CLK       8'h17
`define GCR_MASK_SER_CTRL      8'h3f
`define GCR_MASK_BUS_MON       8'h03
`define GCR_RST_ADDR           8'h00

`endif

// ===== logic/gcr_range_flags.v
// per-channel converter out-of-range flags, synchronised from the converters
`timescale 1ns/1ps
module gcr_range_flags
(
  input  wire       core_clk,
  input  wire       srst,
  input  wire [3:0] over_in,
  input  wire [3:0] under_in,
  output wire [7:0] status
);

  // three-stage synchroniser; a change counts once stages two and three agree
  reg [7:0] s1_ff;
  reg [7:0] s2_ff;
  reg [7:0] s3_ff;
  reg [7:0] flag_ff;
  reg [7:0] nxt_flag;
  integer   i;

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      s1_ff   <= 8'h00;
      s2_ff   <= 8'h00;
      s3_ff   <= 8'h00;
      flag_ff <= 8'h00;
    end
    else
    begin
      s1_ff   <= {under_in, over_in};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      flag_ff <= nxt_flag;
    end
  end

  always @*
  begin
    nxt_flag = flag_ff;
    for (i = 0; i < 8; i = i + 1)
      if (s2_ff[i] == s3_ff[i])
        nxt_flag[i] = s3_ff[i];
  end

  assign status = flag_ff;

endmodule // gcr_range_flags

// ===== logic/gcr_clk_div.v
// power-of-two enable divider: one-cycle pulse every 2**rate cycles for rate 0..6, every 64 cycles for rate 7
`timescale 1ns/1ps
module gcr_clk_div
(
  input  wire       core_clk,
  input  wire       srst,
  input  wire [2:0] rate,
  output wire       tick
);

  reg [5:0] cnt_ff;
  reg       tick_ff;
  wire [5:0] lim;

  assign lim = (6'h01 << rate) - 6'h01;

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      cnt_ff  <= 6'h00;
      tick_ff <= 1'b0;
    end
    else if (cnt_ff >= lim)
    begin
      cnt_ff  <= 6'h00;
      tick_ff <= 1'b1;
    end
    else
    begin
      cnt_ff  <= cnt_ff + 6'h01;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule // gcr_clk_div

// ===== logic/gcr_regs.v
// global configuration register bank behind the serial register port
`timescale 1ns/1ps
`include "gcr_map.vh"

// Behaviour
// R01: status bits 3..0 show channel 4..1 converter out of range high.
// R02: status bits 7..4 show channel 4..1 converter out of range low.
// R03: pll pre-divider M is bits 5..0 of pre-divider register, reset 1.
// R04: bit 6 selects pll range; 1 (reset) is 100-200 MHz.
// R05: pll loop divider N is bits 5..0 of loop register, reset 10.
// R06: converter clock enable divides pll clock by 2,4,8,16; reset 2.
// R07: bit 2 inverts converter clock; reset 0, host leaves it alone.
// R08: system clock is pll clock over 2**N, N at most 6, reset 0.
// R09: eeprom transfer clock enabled while system bit 4 set; resets 1.
// R10: ram run bit keeps coefficient ram refreshed; reset 0.
// R11: host clears ram run only during configure-mode ram access.
// R12: single-channel bit picks output format; 0 means multi-channel.
// R13: parity in multi-channel mode forces word msb for odd ones.
// R14: auto-increment steps the register address after each data byte.
// R15: fastest-channel field picks which channel drives sample ready.
// R16: host keeps fastest-channel pointing at fastest enabled channel.
// R17: monitor enable exposes internal bus; select picks serial or eeprom.
// R18: eeprom start address is 12 bits over two registers.
// R19: on-chip start address is 14 bits over two registers.
// R20: transfer end address is 14 bits over two registers.
// R21: status writes ignored; unused bits read zero.
module gcr_regs
(
  input  wire        core_clk,
  input  wire        srst,
  // serial register port, one byte access per strobe
  input  wire        reg_start,
  input  wire        reg_wr_stb,
  input  wire        reg_rd_stb,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg  [7:0]  reg_cur_addr,
  // converter range inputs
  input  wire [3:0]  chan_over_flag,
  input  wire [3:0]  chan_under_flag,
  // per-channel sample strobes and output word
  input  wire [3:0]  chan_sample_stb,
  input  wire [15:0] chan_word,
  output reg         sample_ready_out,
  output reg  [15:0] ser_word_out,
  output reg         single_channel_mode,
  // clocking controls
  output reg  [5:0]  pll_pre_div,
  output reg         pll_range_high,
  output reg  [5:0]  pll_loop_div,
  output reg         conv_clk_en,
  output reg         conv_clk_invert,
  output reg         sys_clk_en,
  output reg         ee_xfer_clk_en,
  output reg         ram_run_mode,
  // bus monitor
  input  wire [7:0]  sif_bus_data,
  input  wire [7:0]  ee_bus_data,
  input  wire        xfer_active,
  output reg  [7:0]  bus_monitor_out,
  // block transfer addresses
  output reg  [11:0] eeprom_start_addr,
  output reg  [13:0] onchip_start_addr,
  output reg  [13:0] transfer_end_addr
);

  //--------------------------------------------------------------
  // register storage
  //--------------------------------------------------------------
  reg  [7:0]  prediv_ff;
  reg  [7:0]  loop_ff;
  reg  [7:0]  conv_ff;
  reg  [7:0]  sys_ff;
  reg  [7:0]  ser_ff;
  reg  [7:0]  mon_ff;
  reg  [7:0]  ee_lo_ff;
  reg  [7:0]  ee_hi_ff;
  reg  [7:0]  chip_lo_ff;
  reg  [7:0]  chip_hi_ff;
  reg  [7:0]  end_lo_ff;
  reg  [7:0]  end_hi_ff;
  reg  [7:0]  addr_ff;
  reg         first_ff;
  reg  [3:0]  conv_cnt_ff;
  reg  [7:0]  nxt_rdata;
  reg  [2:0]  nxt_sys_rate;
  wire [7:0]  status;
  wire [7:0]  eff_addr;
  wire        sys_tick;
  wire [1:0]  fast_sel;
  wire        par_odd;

  gcr_range_flags u_flags
  (
    .core_clk (core_clk),
    .srst     (srst),
    .over_in  (chan_over_flag),
    .under_in (chan_under_flag),
    .status   (status)
  );

  gcr_clk_div u_sysdiv
  (
    .core_clk (core_clk),
    .srst     (srst),
    .rate     (sys_ff[`GCR_SYS_RATE_MSB:0]),
    .tick     (sys_tick)
  );

  // address of the current byte: first byte uses the given address
  assign eff_addr = first_ff ? reg_addr : addr_ff;

  // read decode shared by the read path
  function [7:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `GCR_OFS_RANGE_STATUS: rd_mux = status;    // [R01] [R02]
        `GCR_OFS_PLL_PREDIV:   rd_mux = prediv_ff;
        `GCR_OFS_PLL_LOOP:     rd_mux = loop_ff;
        `GCR_OFS_CONV_CLK:     rd_mux = conv_ff;
        `GCR_OFS_SYS_CLK:      rd_mux = sys_ff;
        `GCR_OFS_SER_CTRL:     rd_mux = ser_ff;
        `GCR_OFS_BUS_MON:      rd_mux = mon_ff;
        `GCR_OFS_EE_ST_LO:     rd_mux = ee_lo_ff;
        `GCR_OFS_EE_ST_HI:     rd_mux = ee_hi_ff;
        `GCR_OFS_CHIP_ST_LO:   rd_mux = chip_lo_ff;
        `GCR_OFS_CHIP_ST_HI:   rd_mux = chip_hi_ff;
        `GCR_OFS_END_LO:       rd_mux = end_lo_ff;
        `GCR_OFS_END_HI:       rd_mux = end_hi_ff;
        default:               rd_mux = 8'h00;     // [R21]
      endcase
    end
  endfunction

  always @*
  begin
    nxt_rdata = rd_mux(eff_addr);
  end

  // clamp: a rate of seven would divide by 64, not by 128
  always @*
  begin
    if (reg_wdata[`GCR_SYS_RATE_MSB:0] > `GCR_SYS_RATE_MAX)
      nxt_sys_rate = `GCR_SYS_RATE_MAX;                             // [R08]
    else
      nxt_sys_rate = reg_wdata[`GCR_SYS_RATE_MSB:0];
  end

  //--------------------------------------------------------------
  // address stepping
  //--------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      addr_ff      <= 8'h00;
      first_ff     <= 1'b1;
      reg_cur_addr <= 8'h00;
    end
    else if (reg_start)
      first_ff <= 1'b1;
    else if (reg_wr_stb || reg_rd_stb)
    begin
      // without auto-increment every byte rereads the given address
      first_ff <= ~ser_ff[`GCR_SER_AUTOINC_BIT];
      addr_ff  <= eff_addr + 8'h01;                                 // [R14]
      if (reg_wr_stb)
        reg_cur_addr <= eff_addr;
    end
  end

  //--------------------------------------------------------------
  // read data
  //--------------------------------------------------------------
  // read data stands until the next read strobe
  always @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd_stb && !reg_start)
      reg_rdata <= nxt_rdata;
  end

  //--------------------------------------------------------------
  // host register writes
  //--------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      prediv_ff  <= `GCR_RST_PREDIV;                                // [R03] [R04]
      loop_ff    <= `GCR_RST_LOOP;                                  // [R05]
      conv_ff    <= `GCR_RST_CONV_CLK;                              // [R06] [R07]
      sys_ff     <= `GCR_RST_SYS_CLK;                               // [R08] [R09]
      ser_ff     <= `GCR_RST_SER_CTRL;                              // [R10] [R12]
      mon_ff     <= `GCR_RST_BUS_MON;
      ee_lo_ff   <= `GCR_RST_ADDR;
      ee_hi_ff   <= `GCR_RST_ADDR;
      chip_lo_ff <= `GCR_RST_ADDR;
      chip_hi_ff <= `GCR_RST_ADDR;
      end_lo_ff  <= `GCR_RST_ADDR;
      end_hi_ff  <= `GCR_RST_ADDR;
    end
    else
    begin
      if (reg_wr_stb && !reg_start)
      begin
        case (eff_addr)
          `GCR_OFS_PLL_PREDIV: prediv_ff  <= reg_wdata & `GCR_MASK_PREDIV;
          `GCR_OFS_PLL_LOOP:   loop_ff    <= reg_wdata & `GCR_MASK_LOOP;
          `GCR_OFS_CONV_CLK:   conv_ff    <= reg_wdata & `GCR_MASK_CONV_CLK;
          `GCR_OFS_SYS_CLK:    sys_ff     <= {3'h0, reg_wdata[`GCR_SYS_EE_EN_BIT],
                                              1'b0, nxt_sys_rate};
          `GCR_OFS_SER_CTRL:   ser_ff     <= reg_wdata & `GCR_MASK_SER_CTRL;
          `GCR_OFS_BUS_MON:    mon_ff     <= reg_wdata & `GCR_MASK_BUS_MON;
          `GCR_OFS_EE_ST_LO:   ee_lo_ff   <= reg_wdata;             // [R18]
          `GCR_OFS_EE_ST_HI:   ee_hi_ff   <= reg_wdata & `GCR_MASK_EE_HI;
          `GCR_OFS_CHIP_ST_LO: chip_lo_ff <= reg_wdata;             // [R19]
          `GCR_OFS_CHIP_ST_HI: chip_hi_ff <= reg_wdata & `GCR_MASK_CHIP_HI;
          `GCR_OFS_END_LO:     end_lo_ff  <= reg_wdata;             // [R20]
          `GCR_OFS_END_HI:     end_hi_ff  <= reg_wdata & `GCR_MASK_CHIP_HI;
          default:             ;                                    // [R21]
        endcase
      end
    end
  end

  //--------------------------------------------------------------
  // converter clock enable: pll clock over 2,4,8,16
  //--------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      conv_cnt_ff <= 4'h0;
      conv_clk_en <= 1'b0;
    end
    else if (conv_cnt_ff >= ((4'h2 << conv_ff[1:0]) - 4'h1))        // [R06]
    begin
      conv_cnt_ff <= 4'h0;
      conv_clk_en <= 1'b1;
    end
    else
    begin
      conv_cnt_ff <= conv_cnt_ff + 4'h1;
      conv_clk_en <= 1'b0;
    end
  end

  //--------------------------------------------------------------
  // output data path
  //--------------------------------------------------------------
  assign fast_sel = ser_ff[`GCR_SER_FAST_LSB+1:`GCR_SER_FAST_LSB];
  // odd parity over the fifteen data bits decides the msb
  assign par_odd  = ~(^chan_word[14:0]);

  always @(posedge core_clk)
  begin
    if (srst)
    begin
      sample_ready_out    <= 1'b0;
      single_channel_mode <= 1'b0;
    end
    else
    begin
      sample_ready_out    <= chan_sample_stb[fast_sel];             // [R15]
      single_channel_mode <= ser_ff[`GCR_SER_SINGLE_BIT];           // [R12]
    end
  end

  // single-channel words always pass untouched, parity or not
  always @(posedge core_clk)
  begin
    if (srst)
      ser_word_out <= 16'h0000;
    else if (ser_ff[`GCR_SER_PARITY_BIT] && !ser_ff[`GCR_SER_SINGLE_BIT])
      ser_word_out <= {par_odd, chan_word[14:0]};                   // [R13]
    else
      ser_word_out <= chan_word;
  end

  //--------------------------------------------------------------
  // bus monitor
  //--------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (srst)
      bus_monitor_out <= 8'h00;
    else if (mon_ff[`GCR_MON_EN_BIT] && xfer_active)                // [R17]
      bus_monitor_out <= mon_ff[`GCR_MON_SEL_BIT] ? ee_bus_data : sif_bus_data;
    else
      bus_monitor_out <= 8'h00;
  end

  //--------------------------------------------------------------
  // pll controls
  //--------------------------------------------------------------
  // fields leave one cycle late, so the pll only ever sees a settled word
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      pll_pre_div    <= 6'h01;
      pll_range_high <= 1'b1;
      pll_loop_div   <= 6'h0a;
    end
    else
    begin
      pll_pre_div    <= prediv_ff[`GCR_PREDIV_M_MSB:0];             // [R03]
      pll_range_high <= prediv_ff[`GCR_PREDIV_RANGE_BIT];           // [R04]
      pll_loop_div   <= loop_ff[5:0];                               // [R05]
    end
  end

  //--------------------------------------------------------------
  // clock enables and modes
  //--------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      conv_clk_invert <= 1'b0;
      sys_clk_en      <= 1'b0;
      ee_xfer_clk_en  <= 1'b0;
      ram_run_mode    <= 1'b0;
    end
    else
    begin
      conv_clk_invert <= conv_ff[`GCR_CONV_INV_BIT];                // [R07]
      sys_clk_en      <= sys_tick;                                  // [R08]
      ee_xfer_clk_en  <= sys_tick & sys_ff[`GCR_SYS_EE_EN_BIT];     // [R09]
      ram_run_mode    <= ser_ff[`GCR_SER_RAM_RUN_BIT];              // [R10]
    end
  end

  //--------------------------------------------------------------
  // block transfer addresses
  //--------------------------------------------------------------
  // low and high bytes land apart; the pair is only whole once both are in
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      eeprom_start_addr <= 12'h000;
      onchip_start_addr <= 14'h0000;
      transfer_end_addr <= 14'h0000;
    end
    else
    begin
      eeprom_start_addr <= {ee_hi_ff[3:0], ee_lo_ff};               // [R18]
      onchip_start_addr <= {chip_hi_ff[5:0], chip_lo_ff};           // [R19]
      transfer_end_addr <= {end_hi_ff[5:0], end_lo_ff};             // [R20]
    end
  end

endmodule // gcr_regs

// ===== sim/gcr_regs_sva.sv
// assertion checker for the global configuration register bank
`timescale 1ns/1ps
module gcr_regs_sva
(
  input wire        core_clk,
  input wire        srst,
  input wire        reg_wr_stb,
  input wire        reg_rd_stb,
  input wire [7:0]  reg_rdata,
  input wire [3:0]  chan_sample_stb,
  input wire [15:0] chan_word,
  input wire        sample_ready_out,
  input wire [15:0] ser_word_out,
  input wire        single_channel_mode,
  input wire [5:0]  pll_pre_div,
  input wire        pll_range_high,
  input wire [5:0]  pll_loop_div,
  input wire        conv_clk_en,
  input wire        conv_clk_invert,
  input wire        sys_clk_en,
  input wire        ee_xfer_clk_en,
  input wire        ram_run_mode,
  input wire [7:0]  sif_bus_data,
  input wire [7:0]  ee_bus_data,
  input wire        xfer_active,
  input wire [7:0]  bus_monitor_out,
  input wire [11:0] eeprom_start_addr,
  input wire [13:0] onchip_start_addr,
  input wire [13:0] transfer_end_addr
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // -----------------------------
  // properties
  // -----------------------------
  rst_vals_a: assert property (disable iff (1'b0)
    srst ##1 srst |=> pll_pre_div == 6'h01 && pll_range_high && pll_loop_div == 6'h0a)
    else $error("control outputs wrong after reset");
  pll_hold_a: assert property (
    $changed({pll_range_high, pll_pre_div, pll_loop_div}) |->
    $past(reg_wr_stb, 2) || $past(reg_wr_stb, 3) || $past(srst))
    else $error("pll control moved without a write");
  mode_hold_a: assert property (
    $changed({conv_clk_invert, ram_run_mode, single_channel_mode}) |->
    $past(reg_wr_stb, 2) || $past(reg_wr_stb, 3) || $past(srst))
    else $error("mode output moved without a write");
  addr_hold_a: assert property (
    $changed({eeprom_start_addr, onchip_start_addr, transfer_end_addr}) |->
    $past(reg_wr_stb, 2) || $past(reg_wr_stb, 3) || $past(srst))
    else $error("transfer address moved without a write");
  rdata_hold_a: assert property (
    !$past(reg_rd_stb) && !$past(reg_rd_stb, 2) && !$past(srst) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  ready_src_a: assert property (sample_ready_out |-> $past(|chan_sample_stb))
    else $error("sample ready without a channel strobe");
  word_par_a: assert property (!$past(srst) |->
    ser_word_out[14:0] == $past(chan_word[14:0]) && (ser_word_out[15] == $past(chan_word[15])
    || (^ser_word_out && !single_channel_mode)))
    else $error("output word msb forced wrongly");
  mon_src_a: assert property (bus_monitor_out != 8'h00 |-> $past(xfer_active) &&
    (bus_monitor_out == $past(sif_bus_data) || bus_monitor_out == $past(ee_bus_data)))
    else $error("monitor output without a transfer");
  conv_gap_a: assert property (conv_clk_en |=> !conv_clk_en)
    else $error("converter enable wider than one cycle");
  ee_gate_a: assert property (ee_xfer_clk_en |-> sys_clk_en)
    else $error("eeprom enable off the system tick");

  cover property (sample_ready_out);
  cover property (bus_monitor_out != 8'h00);
  cover property ($changed(eeprom_start_addr));
endmodule // gcr_regs_sva

bind gcr_regs gcr_regs_sva i_sva (.*);

// ===== sim/gcr_host.sv
// host model issuing byte accesses on the register port
`timescale 1ns/1ps
module gcr_host
(
  input  wire       core_clk,
  input  wire [7:0] reg_rdata,
  output reg        reg_start,
  output reg        reg_wr_stb,
  output reg        reg_rd_stb,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata
);
  initial {reg_start, reg_wr_stb, reg_rd_stb, reg_addr, reg_wdata} = 19'h0_0000;

  // k: 4 start, 2 write, 1 read; all accesses are configure mode, so the
  // ram run bit may be cleared freely
  task xfer(input [2:0] k, input [7:0] v, output [7:0] q);
    begin
      @(negedge core_clk);
      {reg_start, reg_wr_stb, reg_rd_stb} = k;
      if (k[2])
        reg_addr = v;
      else
        reg_wdata = v;
      @(negedge core_clk);
      {reg_start, reg_wr_stb, reg_rd_stb} = 3'h0;
      // released data must not look valid
      reg_wdata = ~reg_wdata;
      @(negedge core_clk);
      q = reg_rdata;
    end
  endtask
endmodule // gcr_host

// ===== sim/testbench.sv
// self-checking testbench for the global configuration register bank
`timescale 1ns/1ps
module testbench;
  reg         core_clk = 1'b0;
  reg         srst = 1'b1;
  reg  [3:0]  chan_over_flag = 4'h0;
  reg  [3:0]  chan_under_flag = 4'h0;
  reg  [3:0]  chan_sample_stb = 4'h0;
  reg  [15:0] chan_word = 16'h0000;
  reg  [7:0]  sif_bus_data = 8'h00;
  reg  [7:0]  ee_bus_data = 8'h00;
  reg         xfer_active = 1'b0;
  wire        reg_start, reg_wr_stb, reg_rd_stb;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata, reg_cur_addr, bus_monitor_out;
  wire        sample_ready_out, single_channel_mode, pll_range_high, conv_clk_en;
  wire        conv_clk_invert, sys_clk_en, ee_xfer_clk_en, ram_run_mode;
  wire [15:0] ser_word_out;
  wire [5:0]  pll_pre_div, pll_loop_div;
  wire [11:0] eeprom_start_addr;
  wire [13:0] onchip_start_addr, transfer_end_addr;
  integer     n_mismatch = 0;
  integer     compares = 0;
  // bytes of 0x10..0x1d: reset values, then read-back after writing all ones
  localparam [111:0] rst_t = 112'h0041_0a00_1000_0000_0000_0000_0000;
  localparam [111:0] msk_t = 112'h007f_3f07_163f_03ff_0fff_3fff_3f00;
  // burst bytes for 0x17..0x1c
  localparam [47:0]  bt = 48'h3402_7836_bc2a;

  always #12.5 core_clk = ~core_clk;
  gcr_regs i_dut (.*);
  gcr_host i_host (.*);

  // -----------------------------
  // access and compare tasks
  // -----------------------------
  task chk(input [15:0] g, input [15:0] e);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg [7:0] q;
    begin
      i_host.xfer(3'h4, a, q);
      i_host.xfer(3'h2, d, q);
      repeat (3) @(negedge core_clk);
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    reg [7:0] q;
    begin
      i_host.xfer(3'h4, a, q);
      i_host.xfer(3'h1, 8'h00, q);
      chk({8'h00, q}, {8'h00, e});
    end
  endtask
  task stop_test;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // -----------------------------
  // scenarios
  // -----------------------------
  task t_regs;
    integer i;
    begin
      chk({3'h0, pll_range_high, pll_pre_div, pll_loop_div}, 16'h104a);
      chk({13'h0000, conv_clk_invert, ram_run_mode, single_channel_mode}, 16'h0000);
      for (i = 0; i < 14; i = i + 1)
      begin
        rdc(8'h10 + i[7:0], rst_t[111 - 8 * i -: 8]);
        wr(8'h10 + i[7:0], 8'hff);
        rdc(8'h10 + i[7:0], msk_t[111 - 8 * i -: 8]);
      end
      chk({3'h0, pll_range_high, pll_pre_div, pll_loop_div}, 16'h1fff);
      chk({13'h0000, conv_clk_invert, ram_run_mode, single_channel_mode}, 16'h0007);
    end
  endtask
  task t_burst;
    integer k;
    reg [7:0] q;
    begin
      wr(8'h15, 8'h08);
      i_host.xfer(3'h4, 8'h17, q);
      for (k = 0; k < 6; k = k + 1)
        i_host.xfer(3'h2, bt[47 - 8 * k -: 8], q);
      repeat (3) @(negedge core_clk);
      chk({4'h0, eeprom_start_addr}, 16'h0234);
      chk({2'h0, onchip_start_addr}, 16'h3678);
      chk({2'h0, transfer_end_addr}, 16'h2abc);
      chk({8'h00, reg_cur_addr}, 16'h001c);
      wr(8'h15, 8'h00);
      i_host.xfer(3'h4, 8'h19, q);
      i_host.xfer(3'h2, 8'h11, q);
      i_host.xfer(3'h2, 8'h22, q);
      repeat (3) @(negedge core_clk);
      chk({2'h0, onchip_start_addr}, 16'h3622);
      chk({8'h00, reg_cur_addr}, 16'h0019);
    end
  endtask
  task t_flags;
    begin
      chan_over_flag = 4'h5;
      chan_under_flag = 4'ha;
      repeat (5) @(negedge core_clk);
      rdc(8'h10, 8'ha5);
      chan_over_flag = 4'h0;
      chan_under_flag = 4'h0;
      repeat (5) @(negedge core_clk);
      rdc(8'h10, 8'h00);
    end
  endtask
  task t_fast;
    integer f;
    begin
      for (f = 0; f < 4; f = f + 1)
      begin
        wr(8'h15, {2'h0, f[1:0], 4'h0});
        chan_sample_stb = ~(4'h1 << f);
        @(negedge core_clk);
        chk({15'h0000, sample_ready_out}, 16'h0000);
        chan_sample_stb = 4'h1 << f;
        @(negedge core_clk);
        chk({15'h0000, sample_ready_out}, 16'h0001);
        chan_sample_stb = 4'h0;
      end
    end
  endtask
  task pw(input [15:0] w, input [15:0] e);
    begin
      chan_word = w;
      @(negedge core_clk);
      chk(ser_word_out, e);
    end
  endtask
  task t_par;
    begin
      wr(8'h15, 8'h04);
      pw(16'h8003, 16'h8003);
      pw(16'h8001, 16'h0001);
      pw(16'h0003, 16'h8003);
      wr(8'h15, 8'h06);
      pw(16'h8001, 16'h8001);
      pw(16'h0003, 16'h0003);
      wr(8'h15, 8'h00);
      pw(16'h0003, 16'h0003);
    end
  endtask
  task mw(input [7:0] d, input [15:0] e);
    begin
      wr(8'h16, d);
      chk({8'h00, bus_monitor_out}, e);
    end
  endtask
  task t_mon;
    begin
      sif_bus_data = 8'h5a;
      ee_bus_data = 8'hc3;
      xfer_active = 1'b1;
      mw(8'h01, 16'h005a);
      mw(8'h03, 16'h00c3);
      mw(8'h00, 16'h0000);
      xfer_active = 1'b0;
      mw(8'h03, 16'h0000);
    end
  endtask
  // counts ticks over 128 cycles: converter tick for 0x13, system tick for 0x14
  task cnt(input [7:0] a, input [7:0] d, input [15:0] e);
    integer k;
    reg [15:0] c;
    reg [15:0] c2;
    begin
      wr(a, d);
      c = 16'h0000;
      c2 = 16'h0000;
      for (k = 0; k < 128; k = k + 1)
      begin
        @(negedge core_clk);
        c = c + {15'h0000, a[0] ? conv_clk_en : sys_clk_en};
        c2 = c2 + {15'h0000, ee_xfer_clk_en};
      end
      chk(c, e);
      if (!a[0])
        chk(c2, d[4] ? e : 16'h0000);
    end
  endtask
  task t_div;
    integer r;
    begin
      for (r = 0; r < 4; r = r + 1)
        cnt(8'h13, {6'h00, r[1:0]}, 16'h0080 >> (r + 1));
      cnt(8'h14, 8'h16, 16'h0002);
      cnt(8'h14, 8'h02, 16'h0020);
      cnt(8'h14, 8'h10, 16'h0080);
    end
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    t_regs;
    t_burst;
    t_flags;
    t_fast;
    t_par;
    t_mon;
    t_div;
    stop_test;
  end
  initial
  begin
    #400000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
endmodule // testbench
